// File: common/ttc_consts.svh
// Functional notes
// - Mode 0 count is 13 bits wide
// - Mode 0: high byte plus low five bits
// - Rollover to zero sets timer zero overflow flag
// - Count enabled by run and gate-or-pin
// - Gate bits at mode register bits 3, 7
// - Setting run bit leaves counts untouched
// - No prescaler; one count per clock
// - Mode 1 uses full 16 bits
// - Mode 2: low byte reloads from high byte
// - Split timer zero: timer one mode-3 stops it
// - Modes 0-2 identical for timers zero and one; mode 3 splits zero, holds one
// - Count bytes independent or combined by mode
// - Timer two mode from run, baud, capture bits
// - Autoreload: rollover sets flag, loads reload pair
// - Autoreload: enabled external fall reloads, sets flag
// - Capture mode: free 16-bit count, overflow flag
// - Capture mode: external fall copies count, flag
// - Baud mode never sets timer two overflow flag; the pulse still fires
// - Counter select picks pin or core clock
// - Overflow flag hardware set, software cleared
// - Baud select forces autoreload, ignores capture bit
`ifndef TTC_CONSTS_SVH
`define TTC_CONSTS_SVH

// ****************************************
// Register indices (byte address = 4 * index)
// ****************************************
`define TTC_IDX_CTRL01   8'h88
`define TTC_IDX_MODE01   8'h89
`define TTC_IDX_T0_LO    8'h8A
`define TTC_IDX_T1_LO    8'h8B
`define TTC_IDX_T0_HI    8'h8C
`define TTC_IDX_T1_HI    8'h8D
`define TTC_IDX_CTRL2    8'hC8
`define TTC_IDX_RLD2_LO  8'hCA
`define TTC_IDX_RLD2_HI  8'hCB
`define TTC_IDX_T2_LO    8'hCC
`define TTC_IDX_T2_HI    8'hCD

// ****************************************
// Field positions
// ****************************************
`define TTC_C01_TF1      7
`define TTC_C01_TR1      6
`define TTC_C01_TF0      5
`define TTC_C01_TR0      4
`define TTC_M01_T1_GATE_CTRL    7
`define TTC_M01_CT1      6
`define TTC_M01_MODE1    5:4
`define TTC_M01_T0_GATE_CTRL    3
`define TTC_M01_CT0      2
`define TTC_M01_MODE0    1:0
`define TTC_C2_TF2       7
`define TTC_C2_T2_EXTERNAL_FLAG      6
`define TTC_C2_RCLK      5
`define TTC_C2_TX_BAUD_SELECT      4
`define TTC_C2_T2_EXTERNAL_ENABLE     3
`define TTC_C2_TR2       2
`define TTC_C2_CT2       1
`define TTC_C2_T2_CAPTURE_SELECT      0

// ****************************************
// Reset values
// ****************************************
`define TTC_RST_BYTE     8'h00
`define TTC_RST_WORD     32'h0000_0000
`define TTC_ALL_ONES16   16'hFFFF

`endif

// File: common/ttc_pkg.sv
package ttc_pkg;

	typedef enum logic [1:0] {
		TTC_M13,
		TTC_M16,
		TTC_M8R,
		TTC_MSPLIT
	} ttc_mode_t;

	typedef enum logic [1:0] {
		TTC_T2_OFF,
		TTC_T2_AUTO,
		TTC_T2_CAPT,
		TTC_T2_BAUD
	} ttc_t2mode_t;

endpackage

// File: rtl/ttc_top.sv
// Decided for this implementation: the APB slave port.
`include "ttc_consts.svh"

module ttc_top import ttc_pkg::*; (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External pins, asynchronous
	input  wire logic        ext_irq_zero_pin,
	input  wire logic        ext_irq_one_pin,
	input  wire logic        t0_count_pin,
	input  wire logic        t1_count_pin,
	input  wire logic        t2_count_pin,
	input  wire logic        t2_external_input,
	// Overflow pulses and flags
	output logic             t0_ovf_pulse,
	output logic             t1_ovf_pulse,
	output logic             t2_ovf_pulse,
	output logic             t0_overflow_flag,
	output logic             t1_overflow_flag,
	output logic             t2_overflow_flag,
	output logic             t2_external_flag
);

	// ****************************************
	// Functions
	// ****************************************

	// Returns {overflow, high, low} after one count step
	function automatic logic [16:0] ttc_step(
		input ttc_mode_t  m,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [13:0] c14;
		logic [16:0] c17;
		logic [8:0]  c9;
		c14 = {1'b0, hi, lo[4:0]} + 14'h0001;
		c17 = {1'b0, hi, lo} + 17'h00001;
		c9  = {1'b0, lo} + 9'h001;
		case (m)
			// Upper three low bits are left as they were
			TTC_M13: ttc_step = {c14[13], c14[12:5], lo[7:5], c14[4:0]};
			TTC_M16: ttc_step = c17;
			TTC_M8R: ttc_step = {c9[8], hi, c9[8] ? hi : c9[7:0]};
			TTC_MSPLIT: ttc_step = {c9[8], hi, c9[7:0]};
			default: ttc_step = {1'b0, hi, lo};
		endcase
	endfunction

	function automatic logic ttc_hit(input logic [9:0] a, input logic [7:0] idx);
		ttc_hit = (a[9:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [5:0]  sync1_ff;
	logic [5:0]  sync2_ff;
	logic [5:0]  prev_ff;
	logic        tf0_ff;
	logic        tr0_ff;
	logic        tf1_ff;
	logic        tr1_ff;
	logic [7:0]  timer01_mode_ff;
	logic [7:0]  t0_lo_ff;
	logic [7:0]  t0_hi_ff;
	logic [7:0]  t1_lo_ff;
	logic [7:0]  t1_hi_ff;
	logic        tf2_ff;
	logic        t2_external_flag_ff;
	logic [5:0]  t2ctl_ff;
	logic [7:0]  rld_lo_ff;
	logic [7:0]  rld_hi_ff;
	logic [7:0]  t2_lo_ff;
	logic [7:0]  t2_hi_ff;
	logic        t0_ovf_ff;
	logic        t1_ovf_ff;
	logic        t2_ovf_ff;

	// ****************************************
	// Combinational nets
	// ****************************************
	logic        setup_ph;
	logic        acc_wr;
	logic        any_hit;
	logic [7:0]  rd_byte;
	logic [5:0]  fall;
	logic        ext_irq_zero_pin_s;
	logic        int1_s;
	ttc_mode_t   m0;
	ttc_mode_t   m1;
	logic        t0_split;
	logic        inc0;
	logic        inc0_hi;
	logic        inc1;
	logic [16:0] step0;
	logic [16:0] step1;
	logic [8:0]  hi0_c9;
	logic        ovf0;
	logic        ovf0_hi;
	logic        ovf1;
	logic        set_tf0;
	logic        set_tf1;
	ttc_t2mode_t t2_mode;
	logic        t2_inc;
	logic        t2_ovf;
	logic        t2_ext;
	logic        t2_reload;
	logic        t2_capture;
	logic [15:0] t2_cnt;
	logic [15:0] t2_plus;
	logic        wr_c01;
	logic        wr_m01;
	logic        wr_t0l;
	logic        wr_t0h;
	logic        wr_t1l;
	logic        wr_t1h;
	logic        wr_c2;
	logic        wr_rll;
	logic        wr_rlh;
	logic        wr_t2l;
	logic        wr_t2h;

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state: pready rises in the second access cycle
	assign setup_ph = psel & penable & ~pready_ff;
	assign acc_wr   = psel & penable & pready_ff & pwrite;

	assign wr_c01 = acc_wr & ttc_hit(paddr, `TTC_IDX_CTRL01);
	assign wr_m01 = acc_wr & ttc_hit(paddr, `TTC_IDX_MODE01);
	assign wr_t0l = acc_wr & ttc_hit(paddr, `TTC_IDX_T0_LO);
	assign wr_t0h = acc_wr & ttc_hit(paddr, `TTC_IDX_T0_HI);
	assign wr_t1l = acc_wr & ttc_hit(paddr, `TTC_IDX_T1_LO);
	assign wr_t1h = acc_wr & ttc_hit(paddr, `TTC_IDX_T1_HI);
	assign wr_c2  = acc_wr & ttc_hit(paddr, `TTC_IDX_CTRL2);
	assign wr_rll = acc_wr & ttc_hit(paddr, `TTC_IDX_RLD2_LO);
	assign wr_rlh = acc_wr & ttc_hit(paddr, `TTC_IDX_RLD2_HI);
	assign wr_t2l = acc_wr & ttc_hit(paddr, `TTC_IDX_T2_LO);
	assign wr_t2h = acc_wr & ttc_hit(paddr, `TTC_IDX_T2_HI);

	always_comb begin
		any_hit = 1'b1;
		rd_byte = `TTC_RST_BYTE;
		case (paddr)
			{`TTC_IDX_CTRL01, 2'h0}: rd_byte = {tf1_ff, tr1_ff, tf0_ff, tr0_ff, 4'h0};
			{`TTC_IDX_MODE01, 2'h0}: rd_byte = timer01_mode_ff;
			{`TTC_IDX_T0_LO, 2'h0}: rd_byte = t0_lo_ff;
			{`TTC_IDX_T0_HI, 2'h0}: rd_byte = t0_hi_ff;
			{`TTC_IDX_T1_LO, 2'h0}: rd_byte = t1_lo_ff;
			{`TTC_IDX_T1_HI, 2'h0}: rd_byte = t1_hi_ff;
			{`TTC_IDX_CTRL2, 2'h0}: rd_byte = {tf2_ff, t2_external_flag_ff, t2ctl_ff};
			{`TTC_IDX_RLD2_LO, 2'h0}: rd_byte = rld_lo_ff;
			{`TTC_IDX_RLD2_HI, 2'h0}: rd_byte = rld_hi_ff;
			{`TTC_IDX_T2_LO, 2'h0}: rd_byte = t2_lo_ff;
			{`TTC_IDX_T2_HI, 2'h0}: rd_byte = t2_hi_ff;
			default: any_hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= `TTC_RST_WORD;
		end else begin
			pready_ff  <= setup_ph;
			pslverr_ff <= setup_ph & ~any_hit;
			prdata_ff  <= (setup_ph & ~pwrite) ? {24'h000000, rd_byte} : `TTC_RST_WORD;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// prev_ff is a third stage so edge detection never reads sync1_ff
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 6'h00;
			sync2_ff <= 6'h00;
			prev_ff  <= 6'h00;
		end else begin
			sync1_ff <= {t2_external_input, t2_count_pin, t1_count_pin,
			             t0_count_pin, ext_irq_one_pin, ext_irq_zero_pin};
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	assign fall   = prev_ff & ~sync2_ff;
	assign ext_irq_zero_pin_s = sync2_ff[0];
	assign int1_s = sync2_ff[1];

	// ****************************************
	// Timers 0 and 1
	// ****************************************
	assign m0 = ttc_mode_t'(timer01_mode_ff[`TTC_M01_MODE0]);
	assign m1 = ttc_mode_t'(timer01_mode_ff[`TTC_M01_MODE1]);
	assign t0_split = (m0 == TTC_MSPLIT);

	// Timer mode counts every clock; counter mode counts pin falls
	assign inc0 = tr0_ff & (~timer01_mode_ff[`TTC_M01_T0_GATE_CTRL] | ext_irq_zero_pin_s)
	              & (timer01_mode_ff[`TTC_M01_CT0] ? fall[2] : 1'b1);
	// In split mode the high half borrows timer one's run bit
	assign inc0_hi = t0_split & tr1_ff;
	// Timer one in its own split setting is simply held
	assign inc1 = (m1 != TTC_MSPLIT)
	              & (t0_split | (tr1_ff & (~timer01_mode_ff[`TTC_M01_T1_GATE_CTRL] | int1_s)))
	              & (timer01_mode_ff[`TTC_M01_CT1] ? fall[3] : 1'b1);

	assign step0  = ttc_step(m0, t0_hi_ff, t0_lo_ff);
	assign step1  = ttc_step(m1, t1_hi_ff, t1_lo_ff);
	assign hi0_c9 = {1'b0, t0_hi_ff} + 9'h001;

	assign ovf0    = inc0 & step0[16];
	assign ovf0_hi = inc0_hi & hi0_c9[8];
	assign ovf1    = inc1 & step1[16];
	assign set_tf0 = ovf0;
	// Timer one loses its flag to the split high half
	assign set_tf1 = t0_split ? ovf0_hi : ovf1;

	// Software writes win over a simultaneous count step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0_lo_ff <= `TTC_RST_BYTE;
			t0_hi_ff <= `TTC_RST_BYTE;
		end else begin
			if (wr_t0l)
				t0_lo_ff <= pwdata[7:0];
			else if (inc0)
				t0_lo_ff <= step0[7:0];
			if (wr_t0h)
				t0_hi_ff <= pwdata[7:0];
			else if (inc0_hi)
				t0_hi_ff <= hi0_c9[7:0];
			else if (inc0 && !t0_split)
				t0_hi_ff <= step0[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t1_lo_ff <= `TTC_RST_BYTE;
			t1_hi_ff <= `TTC_RST_BYTE;
		end else begin
			if (wr_t1l)
				t1_lo_ff <= pwdata[7:0];
			else if (inc1)
				t1_lo_ff <= step1[7:0];
			if (wr_t1h)
				t1_hi_ff <= pwdata[7:0];
			else if (inc1)
				t1_hi_ff <= step1[15:8];
		end
	end

	// Run bits only gate counting; the counts are never cleared here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tr0_ff  <= 1'b0;
			tr1_ff  <= 1'b0;
			timer01_mode_ff <= `TTC_RST_BYTE;
		end else begin
			if (wr_c01) begin
				tr0_ff <= pwdata[`TTC_C01_TR0];
				tr1_ff <= pwdata[`TTC_C01_TR1];
			end
			if (wr_m01)
				timer01_mode_ff <= pwdata[7:0];
		end
	end

	// Set beats a same-cycle software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf0_ff <= 1'b0;
			tf1_ff <= 1'b0;
		end else begin
			tf0_ff <= set_tf0 | (wr_c01 ? pwdata[`TTC_C01_TF0] : tf0_ff);
			tf1_ff <= set_tf1 | (wr_c01 ? pwdata[`TTC_C01_TF1] : tf1_ff);
		end
	end

	// ****************************************
	// Timer 2
	// ****************************************
	always_comb begin
		if (!t2ctl_ff[`TTC_C2_TR2])
			t2_mode = TTC_T2_OFF;
		else if (t2ctl_ff[`TTC_C2_RCLK] | t2ctl_ff[`TTC_C2_TX_BAUD_SELECT])
			t2_mode = TTC_T2_BAUD;
		else if (t2ctl_ff[`TTC_C2_T2_CAPTURE_SELECT])
			t2_mode = TTC_T2_CAPT;
		else
			t2_mode = TTC_T2_AUTO;
	end

	assign t2_cnt  = {t2_hi_ff, t2_lo_ff};
	assign t2_plus = t2_cnt + 16'h0001;
	assign t2_inc  = (t2_mode != TTC_T2_OFF)
	                 & (t2ctl_ff[`TTC_C2_CT2] ? fall[4] : 1'b1);
	assign t2_ovf  = t2_inc & (t2_cnt == `TTC_ALL_ONES16);
	assign t2_ext  = t2ctl_ff[`TTC_C2_T2_EXTERNAL_ENABLE] & fall[5] & (t2_mode != TTC_T2_OFF);

	always_comb begin
		t2_reload  = 1'b0;
		t2_capture = 1'b0;
		case (t2_mode)
			TTC_T2_AUTO: t2_reload = t2_ovf | t2_ext;
			TTC_T2_CAPT: t2_capture = t2_ext;
			// Capture bit has no say once a baud select is up
			TTC_T2_BAUD: t2_reload = t2_ovf;
			default: t2_reload = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t2_lo_ff <= `TTC_RST_BYTE;
			t2_hi_ff <= `TTC_RST_BYTE;
		end else begin
			if (wr_t2l)
				t2_lo_ff <= pwdata[7:0];
			else if (t2_reload)
				t2_lo_ff <= rld_lo_ff;
			else if (t2_inc)
				t2_lo_ff <= t2_plus[7:0];
			if (wr_t2h)
				t2_hi_ff <= pwdata[7:0];
			else if (t2_reload)
				t2_hi_ff <= rld_hi_ff;
			else if (t2_inc)
				t2_hi_ff <= t2_plus[15:8];
		end
	end

	// Capture takes the count as it stood before this cycle's step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rld_lo_ff <= `TTC_RST_BYTE;
			rld_hi_ff <= `TTC_RST_BYTE;
		end else begin
			if (wr_rll)
				rld_lo_ff <= pwdata[7:0];
			else if (t2_capture)
				rld_lo_ff <= t2_lo_ff;
			if (wr_rlh)
				rld_hi_ff <= pwdata[7:0];
			else if (t2_capture)
				rld_hi_ff <= t2_hi_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			t2ctl_ff <= 6'h00;
		else if (wr_c2)
			t2ctl_ff <= pwdata[5:0];
	end

	// Baud use still lets the external flag act as a spare interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tf2_ff  <= 1'b0;
			t2_external_flag_ff <= 1'b0;
		end else begin
			tf2_ff  <= (t2_ovf & (t2_mode != TTC_T2_BAUD))
			           | (wr_c2 ? pwdata[`TTC_C2_TF2] : tf2_ff);
			t2_external_flag_ff <= t2_ext | (wr_c2 ? pwdata[`TTC_C2_T2_EXTERNAL_FLAG] : t2_external_flag_ff);
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Timer one pulses even when its flag is borrowed, for baud use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0_ovf_ff <= 1'b0;
			t1_ovf_ff <= 1'b0;
			t2_ovf_ff <= 1'b0;
		end else begin
			t0_ovf_ff <= ovf0;
			t1_ovf_ff <= ovf1;
			t2_ovf_ff <= t2_ovf;
		end
	end

	assign prdata           = prdata_ff;
	assign pready           = pready_ff;
	assign pslverr          = pslverr_ff;
	assign t0_ovf_pulse     = t0_ovf_ff;
	assign t1_ovf_pulse     = t1_ovf_ff;
	assign t2_ovf_pulse     = t2_ovf_ff;
	assign t0_overflow_flag = tf0_ff;
	assign t1_overflow_flag = tf1_ff;
	assign t2_overflow_flag = tf2_ff;
	assign t2_external_flag = t2_external_flag_ff;

endmodule // ttc_top

// File: testbench/ttc_monitor.sv
module ttc_monitor (
	// APB
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [9:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins
	input wire logic        ext_irq_zero_pin,
	input wire logic        ext_irq_one_pin,
	input wire logic        t0_count_pin,
	input wire logic        t1_count_pin,
	input wire logic        t2_count_pin,
	input wire logic        t2_external_input,
	// Events
	input wire logic        t0_ovf_pulse,
	input wire logic        t1_ovf_pulse,
	input wire logic        t2_ovf_pulse,
	input wire logic        t0_overflow_flag,
	input wire logic        t1_overflow_flag,
	input wire logic        t2_overflow_flag,
	input wire logic        t2_external_flag
);
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [9:0] ADDR_C01 = 10'h220;
	localparam logic [9:0] ADDR_C2  = 10'h320;

	logic       wr_c01;
	logic       wr_c2;
	logic       ext_prev_ff;
	logic [7:0] ext_fall_ff;
	logic [7:0] c2_copy_ff;

	assign wr_c01 = psel & penable & pready & pwrite & (paddr == ADDR_C01);
	assign wr_c2  = psel & penable & pready & pwrite & (paddr == ADDR_C2);

	// Timer two mode bits as software last wrote them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c2_copy_ff <= 8'h00;
		end else if (wr_c2) begin
			c2_copy_ff <= pwdata[7:0];
		end
	end

	// Wide history window absorbs the pin sampler delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev_ff <= 1'b1;
			ext_fall_ff <= 8'h00;
		end else begin
			ext_prev_ff <= t2_external_input;
			ext_fall_ff <= {ext_fall_ff[6:0], ext_prev_ff & ~t2_external_input};
		end
	end

	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_apb_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not in second access cycle");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside ready");
	a_t0_flag_pulse: assert property (
		$rose(t0_overflow_flag) && !$past(wr_c01) |-> t0_ovf_pulse)
		else $error("timer zero flag without pulse");
	a_t0_pulse_flag: assert property (
		t0_ovf_pulse && !$past(wr_c01) |-> t0_overflow_flag)
		else $error("timer zero pulse without flag");
	a_t0_sw_clear: assert property (
		$fell(t0_overflow_flag) |-> $past(wr_c01))
		else $error("timer zero flag cleared by hardware");
	a_t2_baud_noflag: assert property (
		$rose(t2_overflow_flag) && !$past(wr_c2) |-> !$past(c2_copy_ff[5] | c2_copy_ff[4]))
		else $error("timer two flag set in baud mode");
	a_t2_sw_clear: assert property (
		$fell(t2_overflow_flag) |-> $past(wr_c2))
		else $error("timer two flag cleared by hardware");
	a_t2_flag_pulse: assert property (
		$rose(t2_overflow_flag) && !$past(wr_c2) |-> t2_ovf_pulse)
		else $error("timer two flag without pulse");
	a_t2_ext_cause: assert property (
		$rose(t2_external_flag) && !$past(wr_c2) |-> (|ext_fall_ff) && $past(c2_copy_ff[3]))
		else $error("external flag without enabled fall");

	c_t0_overflow: cover property ($rose(t0_overflow_flag));
	c_t2_trigger: cover property ($rose(t2_external_flag));
	c_bad_address: cover property (pready && pslverr);
endmodule // ttc_monitor

bind ttc_top ttc_monitor u_monitor (.*);

// File: testbench/ttc_pin_model.sv
module ttc_pin_model (
	// Clock
	input wire logic pclk,
	// Pins toward the block
	output logic     ext_irq_zero_pin,
	output logic     ext_irq_one_pin,
	output logic     t0_count_pin,
	output logic     t1_count_pin,
	output logic     t2_count_pin,
	output logic     t2_external_input
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle high: gates open, no edge pending
	logic [5:0] pins_ff = 6'h3F;

	assign {t2_external_input, t2_count_pin, t1_count_pin,
		t0_count_pin, ext_irq_one_pin, ext_irq_zero_pin} = pins_ff;

	// Gate level; high lets the timer count
	task drive(input int i, input logic v);
		pins_ff[i] <= v;
		@(posedge pclk);
	endtask

	// Low long enough for the two-flop sampler to see it
	task fall(input int i);
		pins_ff[i] <= 1'b0;
		repeat (4) @(posedge pclk);
		pins_ff[i] <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask
endmodule // ttc_pin_model

// File: testbench/tb.sv
`include "ttc_consts.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        ext_irq_zero_pin, ext_irq_one_pin, t0_count_pin, t1_count_pin;
	logic        t2_count_pin, t2_external_input, t0_ovf_pulse, t1_ovf_pulse;
	logic        t2_ovf_pulse, t0_overflow_flag, t1_overflow_flag;
	logic        t2_overflow_flag, t2_external_flag;
	logic [7:0]  rd, x;
	int          fail_count, compares;
	int          p_cnt [3];

	ttc_top dut (.*);
	ttc_pin_model pins (.*);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Overflow pulses stand one cycle, so they are tallied at every edge
	always_ff @(posedge pclk) begin
		if (t0_ovf_pulse === 1'b1)
			p_cnt[0] <= p_cnt[0] + 1;
		if (t1_ovf_pulse === 1'b1)
			p_cnt[1] <= p_cnt[1] + 1;
		if (t2_ovf_pulse === 1'b1)
			p_cnt[2] <= p_cnt[2] + 1;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task tally_and_finish();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Ready is judged at the rising edge; one idle edge keeps psel from toggling twice
	task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h00_0000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail_count++;
			tally_and_finish();
		end
		rd = prdata[7:0];
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask

	task rc(input string nm, input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		chk(nm, e, rd);
	endtask

	task nz(input string nm, input logic [7:0] i);
		apb(1'b0, i, 8'h00);
		chk(nm, 8'h01, {7'h00, rd != 8'h00});
	endtask

	task wflag(input logic [7:0] i, input int b);
		int n;
		n = 0;
		do begin
			apb(1'b0, i, 8'h00);
			n++;
		end while (rd[b] !== 1'b1 && n < 100);
		if (n >= 100) begin
			fail_count++;
			tally_and_finish();
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs();
		logic [7:0] r [11];
		r = '{`TTC_IDX_CTRL01, `TTC_IDX_CTRL2, `TTC_IDX_MODE01, `TTC_IDX_T0_LO,
			`TTC_IDX_T1_LO, `TTC_IDX_T0_HI, `TTC_IDX_T1_HI, `TTC_IDX_RLD2_LO,
			`TTC_IDX_RLD2_HI, `TTC_IDX_T2_LO, `TTC_IDX_T2_HI};
		foreach (r[k]) rc("reset value", r[k], 8'h00);
		for (int k = 2; k < 11; k++) begin
			wr(r[k], 8'hA5);
			rc("write back", r[k], 8'hA5);
			wr(r[k], 8'h00);
		end
		apb(1'b1, 8'h8E, 8'hFF);
		chk("unmapped error", 8'h01, {7'h00, er});
		$display("test regs done");
	endtask

	task t_wide(input logic t1, input logic [1:0] m, input logic [7:0] hexp);
		logic [7:0] lo, hi;
		lo = t1 ? `TTC_IDX_T1_LO : `TTC_IDX_T0_LO;
		hi = t1 ? `TTC_IDX_T1_HI : `TTC_IDX_T0_HI;
		wr(`TTC_IDX_MODE01, t1 ? {2'b00, m, 4'h0} : {6'h00, m});
		wr(hi, 8'h00);
		wr(lo, 8'h1E);
		wr(`TTC_IDX_CTRL01, t1 ? 8'h40 : 8'h10);
		wr(`TTC_IDX_CTRL01, 8'h00);
		rc("count high", hi, hexp);
		apb(1'b0, lo, 8'h00);
		chk("count low", 8'h01, {7'h00, m[0] ? rd > 8'h1E : rd[4:0] < 5'h1E});
		$display("test wide done");
	endtask

	task t_gate();
		wr(`TTC_IDX_MODE01, 8'h09);
		pins.drive(0, 1'b0);
		wr(`TTC_IDX_T0_LO, 8'h00);
		wr(`TTC_IDX_CTRL01, 8'h10);
		rc("gated low", `TTC_IDX_T0_LO, 8'h00);
		pins.drive(0, 1'b1);
		repeat (6) @(posedge pclk);
		wr(`TTC_IDX_CTRL01, 8'h00);
		nz("gate open", `TTC_IDX_T0_LO);
		$display("test gate done");
	endtask

	task t_reload8();
		int b;
		b = p_cnt[0];
		wr(`TTC_IDX_MODE01, 8'h02);
		wr(`TTC_IDX_T0_HI, 8'hA5);
		wr(`TTC_IDX_T0_LO, 8'hFC);
		wr(`TTC_IDX_CTRL01, 8'h10);
		wflag(`TTC_IDX_CTRL01, 5);
		chk("t0 flag pin", 8'h01, {7'h00, t0_overflow_flag});
		wr(`TTC_IDX_CTRL01, 8'h00);
		rc("reload source", `TTC_IDX_T0_HI, 8'hA5);
		apb(1'b0, `TTC_IDX_T0_LO, 8'h00);
		chk("reloaded low", 8'h01, {7'h00, rd >= 8'hA5});
		rc("flag cleared", `TTC_IDX_CTRL01, 8'h00);
		chk("t0 pulses", 8'h01, 8'(p_cnt[0] - b));
		$display("test reload8 done");
	endtask

	task t_split();
		wr(`TTC_IDX_T1_LO, 8'h00);
		wr(`TTC_IDX_T0_HI, 8'h00);
		wr(`TTC_IDX_MODE01, 8'h33);
		wr(`TTC_IDX_CTRL01, 8'h50);
		rc("timer one held", `TTC_IDX_T1_LO, 8'h00);
		nz("split high", `TTC_IDX_T0_HI);
		wr(`TTC_IDX_MODE01, 8'h13);
		wr(`TTC_IDX_CTRL01, 8'h00);
		nz("timer one runs", `TTC_IDX_T1_LO);
		wr(`TTC_IDX_MODE01, 8'h00);
		$display("test split done");
	endtask

	// Timer one gated by its pin, timer zero counting pin falls
	task t_t1_pins();
		int b;
		b = p_cnt[1];
		wr(`TTC_IDX_MODE01, 8'h95);
		wr(`TTC_IDX_T0_LO, 8'h00);
		wr(`TTC_IDX_T1_HI, 8'hFF);
		wr(`TTC_IDX_T1_LO, 8'hFE);
		pins.drive(1, 1'b0);
		repeat (2) @(posedge pclk);
		wr(`TTC_IDX_CTRL01, 8'h50);
		repeat (2) pins.fall(2);
		rc("gate one shut", `TTC_IDX_T1_LO, 8'hFE);
		rc("pin count zero", `TTC_IDX_T0_LO, 8'h02);
		pins.drive(1, 1'b1);
		wflag(`TTC_IDX_CTRL01, 7);
		chk("t1 flag pin", 8'h01, {7'h00, t1_overflow_flag});
		wr(`TTC_IDX_CTRL01, 8'h00);
		chk("t1 pulses", 8'h01, 8'(p_cnt[1] - b));
		wr(`TTC_IDX_MODE01, 8'h00);
		$display("test t1 pins done");
	endtask

	task t_timer2();
		wr(`TTC_IDX_RLD2_LO, 8'h34);
		wr(`TTC_IDX_RLD2_HI, 8'h12);
		wr(`TTC_IDX_T2_HI, 8'hFF);
		wr(`TTC_IDX_T2_LO, 8'hF0);
		wr(`TTC_IDX_CTRL2, 8'h04);
		wflag(`TTC_IDX_CTRL2, 7);
		chk("t2 flag pin", 8'h01, {7'h00, t2_overflow_flag});
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("auto reload", `TTC_IDX_T2_HI, 8'h12);
		apb(1'b0, `TTC_IDX_T2_LO, 8'h00);
		x = rd;
		rc("off holds", `TTC_IDX_T2_LO, x);
		wr(`TTC_IDX_T2_HI, 8'h00);
		wr(`TTC_IDX_CTRL2, 8'h0C);
		pins.fall(5);
		rc("trigger flag", `TTC_IDX_CTRL2, 8'h4C);
		chk("ext flag pin", 8'h01, {7'h00, t2_external_flag});
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("trigger reload", `TTC_IDX_T2_HI, 8'h12);
		wr(`TTC_IDX_T2_HI, 8'h55);
		wr(`TTC_IDX_CTRL2, 8'h0D);
		pins.fall(5);
		rc("capture flag", `TTC_IDX_CTRL2, 8'h4D);
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("captured", `TTC_IDX_RLD2_HI, 8'h55);
		$display("test timer2 done");
	endtask

	task t_t2_more();
		int b;
		wr(`TTC_IDX_T2_HI, 8'hFF);
		wr(`TTC_IDX_T2_LO, 8'hF0);
		wr(`TTC_IDX_CTRL2, 8'h05);
		wflag(`TTC_IDX_CTRL2, 7);
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("free rollover", `TTC_IDX_T2_HI, 8'h00);
		wr(`TTC_IDX_T2_HI, 8'hFF);
		wr(`TTC_IDX_T2_LO, 8'hF0);
		b = p_cnt[2];
		wr(`TTC_IDX_CTRL2, 8'h15);
		repeat (40) @(posedge pclk);
		rc("baud no flag", `TTC_IDX_CTRL2, 8'h15);
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("baud reload", `TTC_IDX_T2_HI, 8'h55);
		chk("baud pulses", 8'h01, 8'(p_cnt[2] - b));
		wr(`TTC_IDX_T2_LO, 8'h00);
		wr(`TTC_IDX_CTRL2, 8'h06);
		repeat (3) pins.fall(4);
		wr(`TTC_IDX_CTRL2, 8'h00);
		rc("pin count", `TTC_IDX_T2_LO, 8'h03);
		$display("test t2 more done");
	endtask

	initial begin
		fail_count = 0;
		compares = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h000;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_wide(1'b0, 2'b00, 8'h01);
		t_wide(1'b0, 2'b01, 8'h00);
		t_wide(1'b1, 2'b00, 8'h01);
		t_wide(1'b1, 2'b01, 8'h00);
		t_gate();
		t_reload8();
		t_split();
		t_t1_pins();
		t_timer2();
		t_t2_more();
		tally_and_finish();
	end
endmodule // tb
